// ===== hw/pot_counter.sv
// Down counter with direct load and reload on underflow.
// Assumes the controller never asserts load and dec to mean both; load wins.
`timescale 1ns/1ps
`include "pot_map.svh"
module pot_counter import pot_pkg::*; #(
   parameter int W = 8,
   parameter logic [7:0] RST_VAL = `POT_RST_COUNT
) (
   input wire logic clk,
   input wire logic rst,
   pot_cnt_if.cnt c
);
   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;

   assign c.under = c.dec && (count_reg == '0);
   assign c.count = count_reg;

   always_comb begin
      count_next = count_reg;
      if (c.load) begin
         count_next = c.load_val;
      end else if (c.under) begin
         count_next = c.reload_val;
      end else if (c.dec) begin
         count_next = count_reg - W'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_reg <= W'(RST_VAL);
      end else begin
         count_reg <= count_next;
      end
   end
endmodule : pot_counter

// ===== hw/pot_timer.sv
// Eight-bit prescaled down-count timer with one-shot, wait one-shot and waveform modes.
// Assumes an APB master on clk and a synchronous trigger pin.
// How it works
// - After reset the timer is idle; software loads values before starting.
// - Prescaler and counter read as separate registers; count may move between.
// - In one-shot modes, stop or one-shot stop reloads counters then halts.
// - Status flag rises one to two count-source cycles after start set.
// - Status flag falls one to two count-source cycles after start cleared.
// - Forced stop halts counting at once.
// - One-shot status follows start or stop writes after one to two cycles.
// - Crossing one-shot start and stop writes may leave either status.
// - With the pin direction set to input, port data reads pulse level.
// - Forced stop in waveform primary period resets prescaler and primary.
// - Wait one-shot: new secondary and primary apply from the next pulse.
// - Wait mode: primary underflow loads secondary; secondary underflow ends one-shot.
// - Wait and pulse times are (prescaler+1) times (primary or secondary+1).
// - Timer event pulses with the end of the output pulse in one-shot modes, and with its start in waveform mode.
// - Writes while stopped load counters too; while counting only reload registers.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "pot_map.svh"
module pot_timer import pot_pkg::*; #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`POT_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_count_tick,
   input wire logic external_trigger_pin,
   output logic pulse_output_pin,
   output logic timer_event
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic start_reg, start_next;
   logic stat_s1_reg, stat_s1_next;
   logic stat_reg, stat_next;
   logic os_go_reg, os_go_next;
   logic os_go_s1_reg, os_go_s1_next;
   logic os_halt_reg, os_halt_next;
   logic os_halt_s1_reg, os_halt_s1_next;
   logic os_flag_reg, os_flag_next;
   logic [2:0] pin_reg, pin_next;
   logic [3:0] mode_reg, mode_next;
   logic port_latch_reg, port_latch_next;
   logic [W-1:0] pre_rld_reg, pre_rld_next;
   logic [W-1:0] pri_rld_reg, pri_rld_next;
   logic [W-1:0] sec_rld_reg, sec_rld_next;
   pot_phase_e phase_reg, phase_next;
   logic trig_prev_reg;
   logic [2:0] div_reg;
   logic pulse_reg, pulse_next;
   logic event_reg, event_next;
   logic [31:0] rdata_reg, rdata_next;

   pot_cnt_if #(.W(W)) pre_if ();
   pot_cnt_if #(.W(W)) pri_if ();

   pot_counter #(.W(W), .RST_VAL(`POT_RST_COUNT)) u_pre (
      .clk(clk),
      .rst(rst),
      .c(pre_if.cnt)
   );

   pot_counter #(.W(W), .RST_VAL(`POT_RST_COUNT)) u_pri (
      .clk(clk),
      .rst(rst),
      .c(pri_if.cnt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   function automatic logic hit(input logic [`POT_ADDR_W-1:0] a, input logic [`POT_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   logic wr, rd_setup, mapped;
   logic tick, run, run_tick, trig_edge, one_shot_mode;
   logic stop_evt, fstop, os_go_now, os_halt_now, pri_wave_fs;
   pot_mode_e mode;

   assign mode = pot_mode_e'(mode_reg[`POT_MODE_MSB:`POT_MODE_LSB]);
   assign one_shot_mode = (mode == POT_MD_ONESHOT) || (mode == POT_MD_WAIT);
   assign wr = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped = hit(paddr, `POT_OFF_CTRL) || hit(paddr, `POT_OFF_OSCTRL) ||
                   hit(paddr, `POT_OFF_PINCTRL) || hit(paddr, `POT_OFF_MODE) ||
                   hit(paddr, `POT_OFF_PRESC) || hit(paddr, `POT_OFF_SECOND) ||
                   hit(paddr, `POT_OFF_PRIMARY) || hit(paddr, `POT_OFF_PORT);

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = rdata_reg;
   assign pulse_output_pin = pulse_reg;
   assign timer_event = event_reg;

   // Count source selection
   always_comb begin
      unique case (mode_reg[`POT_SRC_MSB:`POT_SRC_LSB])
         `POT_SRC_F1: tick = 1'b1;
         `POT_SRC_F2: tick = div_reg[0];
         `POT_SRC_F8: tick = (div_reg == `POT_DIV_MAX);
         default: tick = ext_count_tick;
      endcase
   end

   assign trig_edge = external_trigger_pin && !trig_prev_reg && pin_reg[`POT_PIN_TRIG_EN];
   assign fstop = wr && hit(paddr, `POT_OFF_CTRL) && pwdata[`POT_CTRL_FSTOP];
   assign run = stat_reg && (!one_shot_mode || os_flag_reg);
   assign run_tick = tick && run && !fstop;
   assign os_go_now = tick && os_go_s1_reg;
   assign os_halt_now = tick && os_halt_s1_reg;
   // normal stop or one-shot stop reloads
   assign stop_evt = (tick && stat_reg && !stat_s1_reg) || (os_halt_now && one_shot_mode);
   // forced stop in waveform primary period
   assign pri_wave_fs = fstop && stat_reg && (mode == POT_MD_WAVE) && (phase_reg == POT_PH_PRI);

   ////////////////////////////////////////////////////////////////////////////
   // Control and reload registers

   always_comb begin
      start_next = start_reg;
      stat_s1_next = stat_s1_reg;
      stat_next = stat_reg;
      os_go_next = os_go_reg;
      os_go_s1_next = os_go_s1_reg;
      os_halt_next = os_halt_reg;
      os_halt_s1_next = os_halt_s1_reg;
      os_flag_next = os_flag_reg;
      pin_next = pin_reg;
      mode_next = mode_reg;
      port_latch_next = port_latch_reg;
      pre_rld_next = pre_rld_reg;
      pri_rld_next = pri_rld_reg;
      sec_rld_next = sec_rld_reg;
      phase_next = phase_reg;
      event_next = 1'b0;
      if (tick) begin
         stat_s1_next = start_reg;
         stat_next = stat_s1_reg;
      end
      if (tick) begin
         os_go_s1_next = os_go_reg;
         os_halt_s1_next = os_halt_reg;
         os_go_next = 1'b0;
         os_halt_next = 1'b0;
      end
      // stop taken last when both land
      if (os_go_now && stat_reg && one_shot_mode) begin
         os_flag_next = 1'b1;
         phase_next = POT_PH_PRI;
      end
      if (trig_edge && stat_reg && one_shot_mode) begin
         os_flag_next = 1'b1;
      end
      if (os_halt_now) begin
         os_flag_next = 1'b0;
      end
      if (pri_if.under && run_tick) begin
         unique case (mode)
            POT_MD_TIMER: event_next = 1'b1;
            POT_MD_WAVE: begin
               phase_next = (phase_reg == POT_PH_PRI) ? POT_PH_SEC : POT_PH_PRI;
               event_next = (phase_reg == POT_PH_SEC);
            end
            POT_MD_ONESHOT: begin
               os_flag_next = 1'b0;
               event_next = 1'b1;
            end
            POT_MD_WAIT: begin
               if (phase_reg == POT_PH_PRI) begin
                  phase_next = POT_PH_SEC;
               end else begin
                  phase_next = POT_PH_PRI;
                  os_flag_next = 1'b0;
                  event_next = 1'b1;
               end
            end
         endcase
      end
      if (stop_evt) begin
         phase_next = POT_PH_PRI;
         os_flag_next = 1'b0;
      end
      if (wr) begin
         if (hit(paddr, `POT_OFF_CTRL)) begin
            start_next = pwdata[`POT_CTRL_START];
         end
         if (hit(paddr, `POT_OFF_OSCTRL)) begin
            if (pwdata[`POT_OS_START]) begin
               os_go_next = 1'b1;
            end
            if (pwdata[`POT_OS_STOP]) begin
               os_halt_next = 1'b1;
            end
         end
         if (hit(paddr, `POT_OFF_PINCTRL)) begin
            pin_next = pwdata[2:0];
         end
         if (hit(paddr, `POT_OFF_MODE)) begin
            mode_next = pwdata[3:0];
         end
         if (hit(paddr, `POT_OFF_PORT)) begin
            port_latch_next = pwdata[`POT_PORT_DATA];
         end
         if (hit(paddr, `POT_OFF_PRESC)) begin
            pre_rld_next = pwdata[W-1:0];
         end
         if (hit(paddr, `POT_OFF_SECOND)) begin
            sec_rld_next = pwdata[W-1:0];
         end
         if (hit(paddr, `POT_OFF_PRIMARY)) begin
            pri_rld_next = pwdata[W-1:0];
         end
      end
      if (fstop) begin
         start_next = 1'b0;
         stat_s1_next = 1'b0;
         stat_next = 1'b0;
         os_flag_next = 1'b0;
         os_go_next = 1'b0;
         os_go_s1_next = 1'b0;
         phase_next = POT_PH_PRI;
         event_next = 1'b0;
      end
      if (pri_wave_fs) begin
         pre_rld_next = `POT_RST_COUNT;
         pri_rld_next = `POT_RST_COUNT;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter steering

   always_comb begin
      pre_if.load = 1'b0;
      pre_if.load_val = pre_rld_reg;
      pri_if.load = 1'b0;
      pri_if.load_val = pri_rld_reg;
      pre_if.dec = run_tick;
      pri_if.dec = run_tick && pre_if.under;
      pre_if.reload_val = pre_rld_reg;
      // next phase value taken at underflow
      if (((mode == POT_MD_WAVE) || (mode == POT_MD_WAIT)) && (phase_reg == POT_PH_PRI)) begin
         pri_if.reload_val = sec_rld_reg;
      end else begin
         pri_if.reload_val = pri_rld_reg;
      end
      if (stop_evt || fstop) begin
         pre_if.load = 1'b1;
         pri_if.load = 1'b1;
      end
      if (wr && !stat_reg && hit(paddr, `POT_OFF_PRESC)) begin
         pre_if.load = 1'b1;
         pre_if.load_val = pwdata[W-1:0];
      end
      if (wr && !stat_reg && hit(paddr, `POT_OFF_PRIMARY)) begin
         pri_if.load = 1'b1;
         pri_if.load_val = pwdata[W-1:0];
      end
      if (pri_wave_fs) begin
         pre_if.load_val = `POT_RST_COUNT;
         pri_if.load_val = `POT_RST_COUNT;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pulse output and read data

   always_comb begin
      logic active;
      active = 1'b0;
      unique case (mode)
         POT_MD_TIMER: active = 1'b0;
         POT_MD_WAVE: active = stat_reg && (phase_next == POT_PH_PRI);
         POT_MD_ONESHOT: active = os_flag_next;
         POT_MD_WAIT: active = os_flag_next && (phase_next == POT_PH_SEC);
      endcase
      pulse_next = active ^ pin_reg[`POT_PIN_LEVEL];
   end

   always_comb begin
      rdata_next = rdata_reg;
      if (rd_setup) begin
         rdata_next = '0;
         if (hit(paddr, `POT_OFF_CTRL)) begin
            rdata_next[`POT_CTRL_START] = start_reg;
            rdata_next[`POT_CTRL_STATUS] = stat_reg;
         end
         if (hit(paddr, `POT_OFF_OSCTRL)) begin
            rdata_next[`POT_OS_STATUS] = os_flag_reg;
         end
         if (hit(paddr, `POT_OFF_PINCTRL)) begin
            rdata_next[2:0] = pin_reg;
         end
         if (hit(paddr, `POT_OFF_MODE)) begin
            rdata_next[3:0] = mode_reg;
         end
         // each byte read on its own
         if (hit(paddr, `POT_OFF_PRESC)) begin
            rdata_next[W-1:0] = pre_if.count;
         end
         if (hit(paddr, `POT_OFF_SECOND)) begin
            rdata_next[W-1:0] = sec_rld_reg;
         end
         if (hit(paddr, `POT_OFF_PRIMARY)) begin
            rdata_next[W-1:0] = pri_if.count;
         end
         if (hit(paddr, `POT_OFF_PORT)) begin
            rdata_next[`POT_PORT_DATA] = pin_reg[`POT_PIN_DIR] ? port_latch_reg : pulse_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         start_reg <= 1'b0;
         stat_s1_reg <= 1'b0;
         stat_reg <= 1'b0;
         os_go_reg <= 1'b0;
         os_go_s1_reg <= 1'b0;
         os_halt_reg <= 1'b0;
         os_halt_s1_reg <= 1'b0;
         os_flag_reg <= 1'b0;
         pin_reg <= '0;
         mode_reg <= '0;
         port_latch_reg <= 1'b0;
         pre_rld_reg <= `POT_RST_COUNT;
         pri_rld_reg <= `POT_RST_COUNT;
         sec_rld_reg <= `POT_RST_COUNT;
         phase_reg <= POT_PH_PRI;
         trig_prev_reg <= 1'b0;
         div_reg <= '0;
         pulse_reg <= 1'b0;
         event_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         start_reg <= start_next;
         stat_s1_reg <= stat_s1_next;
         stat_reg <= stat_next;
         os_go_reg <= os_go_next;
         os_go_s1_reg <= os_go_s1_next;
         os_halt_reg <= os_halt_next;
         os_halt_s1_reg <= os_halt_s1_next;
         os_flag_reg <= os_flag_next;
         pin_reg <= pin_next;
         mode_reg <= mode_next;
         port_latch_reg <= port_latch_next;
         pre_rld_reg <= pre_rld_next;
         pri_rld_reg <= pri_rld_next;
         sec_rld_reg <= sec_rld_next;
         phase_reg <= phase_next;
         trig_prev_reg <= external_trigger_pin;
         div_reg <= div_reg + 3'h1;
         pulse_reg <= pulse_next;
         event_reg <= event_next;
         rdata_reg <= rdata_next;
      end
   end

endmodule : pot_timer

// ===== include/pot_cnt_if.sv
// Link between the timer control and one down-counter cell.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pot_cnt_if #(parameter int W = 8);
   logic load;
   logic [W-1:0] load_val;
   logic dec;
   logic [W-1:0] reload_val;
   logic [W-1:0] count;
   logic under;

   modport ctl (output load, output load_val, output dec, output reload_val, input count, input under);
   modport cnt (input load, input load_val, input dec, input reload_val, output count, output under);
endinterface : pot_cnt_if

// ===== include/pot_map.svh
// Register map, field positions, reset values and timing figures of the one-shot timer.
// Assumes a 32-bit APB with byte addresses and one word per register.
`ifndef POT_MAP_SVH
`define POT_MAP_SVH

`define POT_ADDR_W 8
`define POT_OFF_CTRL 8'h00
`define POT_OFF_OSCTRL 8'h04
`define POT_OFF_PINCTRL 8'h08
`define POT_OFF_MODE 8'h0C
`define POT_OFF_PRESC 8'h10
`define POT_OFF_SECOND 8'h14
`define POT_OFF_PRIMARY 8'h18
`define POT_OFF_PORT 8'h1C

// timer_control_reg
`define POT_CTRL_START 0
`define POT_CTRL_STATUS 1
`define POT_CTRL_FSTOP 2
// one_shot_control_reg
`define POT_OS_START 0
`define POT_OS_STOP 1
`define POT_OS_STATUS 2
// pin_control_reg
`define POT_PIN_LEVEL 0
`define POT_PIN_TRIG_EN 1
`define POT_PIN_DIR 2
// timer_mode_reg
`define POT_MODE_LSB 0
`define POT_MODE_MSB 1
`define POT_SRC_LSB 2
`define POT_SRC_MSB 3
// port data register
`define POT_PORT_DATA 0

`define POT_RST_COUNT 8'hFF
`define POT_DIV_MAX 3'h7
`define POT_SRC_F1 2'h0
`define POT_SRC_F2 2'h1
`define POT_SRC_F8 2'h2

`endif

// ===== include/pot_pkg.sv
// Types shared by the one-shot timer modules.
// Assumes pot_map.svh is included by the modules that need offsets.
package pot_pkg;

   typedef enum logic [1:0] {
      POT_MD_TIMER,
      POT_MD_WAVE,
      POT_MD_ONESHOT,
      POT_MD_WAIT
   } pot_mode_e;

   typedef enum logic {
      POT_PH_PRI,
      POT_PH_SEC
   } pot_phase_e;

   typedef logic [7:0] pot_byte_t;

endpackage : pot_pkg

// ===== test/pot_timer_monitor.sv
// Port checker for the one-shot timer.
// Assumes the pin direction bit stays at input and timer mode never counts.
`timescale 1ns/1ps
`include "pot_map.svh"
module pot_timer_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`POT_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ext_count_tick,
   input wire logic external_trigger_pin,
   input wire logic pulse_output_pin,
   input wire logic timer_event
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////
   property p_idle;
      $fell(rst) |-> (!pulse_output_pin && !timer_event) [*2];
   endproperty
   a_idle: assert property (p_idle) else $error("timer not idle after reset");
   property p_evt_one;
      timer_event |=> !timer_event;
   endproperty
   a_evt_one: assert property (p_evt_one) else $error("event wider than one cycle");
   property p_evt_edge;
      timer_event |-> $changed(pulse_output_pin);
   endproperty
   a_evt_edge: assert property (p_evt_edge) else $error("event without output change");
   property p_port_lvl;
      psel && penable && !pwrite && paddr == `POT_OFF_PORT |-> prdata[0] == $past(pulse_output_pin);
   endproperty
   a_port_lvl: assert property (p_port_lvl) else $error("port read differs from output");
   property p_ready;
      psel && penable |-> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("access phase without ready");
   property p_err_map;
      psel && penable && paddr > `POT_OFF_PORT |-> pslverr;
   endproperty
   a_err_map: assert property (p_err_map) else $error("unmapped access not flagged");
   property p_err_ok;
      psel && penable && paddr <= `POT_OFF_PORT && paddr[1:0] == 2'h0 |-> !pslverr;
   endproperty
   a_err_ok: assert property (p_err_ok) else $error("mapped access flagged");
   property p_err_phase;
      pslverr |-> psel && penable;
   endproperty
   a_err_phase: assert property (p_err_phase) else $error("error outside access phase");
   property p_rd_hold;
      psel && penable |=> $stable(prdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved in access phase");
endmodule : pot_timer_monitor

bind pot_timer pot_timer_monitor u_mon (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .ext_count_tick, .external_trigger_pin, .pulse_output_pin, .timer_event);

// ===== test/pot_timer_tb.sv
// Self-checking bench for the one-shot timer over APB.
// Assumes f1 and f2 count sources from clk; external tick source unused.
`timescale 1ns/1ps
`include "pot_map.svh"
module pot_timer_tb;
   logic clk, rst, psel, penable, pwrite, ext_count_tick, external_trigger_pin;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, pulse_output_pin, timer_event, e;
   int mismatches = 0;
   int tests_run = 0;
   logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
   logic [31:0] rstv [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFF, 32'hFF, 32'hFF};

   pot_timer DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_count_tick(ext_count_tick),
      .external_trigger_pin(external_trigger_pin), .pulse_output_pin(pulse_output_pin),
      .timer_event(timer_event));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk("ready wait", n < 50, 1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, q, exp);
   endtask : rd_chk

   // Wait in clk cycles (with start latency), exact width, event at the end
   task automatic meas(input int wt, input int wd);
      int a, b;
      a = 0;
      b = 0;
      while (pulse_output_pin !== 1'b1 && a < 300) begin
         @(posedge clk);
         #1;
         a++;
      end
      while (pulse_output_pin === 1'b1 && b < 300) begin
         @(posedge clk);
         #1;
         b++;
      end
      chk("wait time", a >= wt && a <= wt + 3, 1);
      chk("pulse width", b, wd);
      chk("event at pulse end", timer_event, 1'b1);
   endtask : meas

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      #(40 * 20000);
      mismatches++;
      close_out();
   end

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ext_count_tick = 1'b0;
      external_trigger_pin = 1'b0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      foreach (offs[i]) rd_chk("reset value", offs[i], rstv[i]);
      chk("idle output", pulse_output_pin, 1'b0);
      $display("test reset done");
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped read", {q[31:1], e}, 32'h1);
      wr(8'h20, 32'h5A);
      chk("unmapped write err", e, 1'b1);
      wr(`POT_OFF_PRESC, 32'h3);
      rd_chk("stopped write", `POT_OFF_PRESC, 32'h3);
      $display("test access done");
      wr(`POT_OFF_MODE, 32'h3);
      wr(`POT_OFF_PRESC, 32'h1);
      wr(`POT_OFF_SECOND, 32'h2);
      wr(`POT_OFF_PRIMARY, 32'h1);
      wr(`POT_OFF_CTRL, 32'h1);
      repeat (3) @(posedge clk);
      rd_chk("count status set", `POT_OFF_CTRL, 32'h3);
      wr(`POT_OFF_OSCTRL, 32'h1);
      meas(4, 6);
      rd_chk("one-shot ended", `POT_OFF_OSCTRL, 32'h0);
      wr(`POT_OFF_SECOND, 32'h0);
      wr(`POT_OFF_PRIMARY, 32'h1);
      wr(`POT_OFF_PINCTRL, 32'h2);
      repeat (2) @(posedge clk);
      external_trigger_pin <= 1'b1;
      @(posedge clk);
      external_trigger_pin <= 1'b0;
      meas(4, 2);
      $display("test wait one-shot done");
      wr(`POT_OFF_PINCTRL, 32'h0);
      wr(`POT_OFF_CTRL, 32'h0);
      repeat (3) @(posedge clk);
      rd_chk("count status clear", `POT_OFF_CTRL, 32'h0);
      wr(`POT_OFF_PRIMARY, 32'h14);
      wr(`POT_OFF_CTRL, 32'h1);
      repeat (3) @(posedge clk);
      wr(`POT_OFF_OSCTRL, 32'h1);
      repeat (8) @(posedge clk);
      apb(1'b0, `POT_OFF_PRIMARY, 32'h0);
      chk("count moving", q < 32'h14 && q > 32'h0, 1);
      wr(`POT_OFF_OSCTRL, 32'h2);
      repeat (4) @(posedge clk);
      chk("no pulse after stop", pulse_output_pin, 1'b0);
      rd_chk("reload on stop", `POT_OFF_PRIMARY, 32'h14);
      rd_chk("one-shot status", `POT_OFF_OSCTRL, 32'h0);
      $display("test one-shot stop done");
      wr(`POT_OFF_CTRL, 32'h4);
      rd_chk("forced stop", `POT_OFF_CTRL, 32'h0);
      wr(`POT_OFF_MODE, 32'h1);
      wr(`POT_OFF_PRESC, 32'h2);
      wr(`POT_OFF_PRIMARY, 32'h3);
      wr(`POT_OFF_SECOND, 32'h3);
      wr(`POT_OFF_CTRL, 32'h1);
      for (int n = 0; n < 200 && pulse_output_pin !== 1'b1; n++) @(posedge clk);
      rd_chk("port level", `POT_OFF_PORT, 32'h1);
      wr(`POT_OFF_CTRL, 32'h4);
      rd_chk("forced stop wave", `POT_OFF_CTRL, 32'h0);
      rd_chk("prescaler reset", `POT_OFF_PRESC, 32'hFF);
      rd_chk("primary reset", `POT_OFF_PRIMARY, 32'hFF);
      $display("test waveform stop done");
      wr(`POT_OFF_MODE, 32'h6);
      wr(`POT_OFF_PRESC, 32'h1);
      wr(`POT_OFF_PRIMARY, 32'h2);
      wr(`POT_OFF_CTRL, 32'h1);
      repeat (6) @(posedge clk);
      wr(`POT_OFF_OSCTRL, 32'h1);
      meas(2, 12);
      rd_chk("one-shot f2 ended", `POT_OFF_OSCTRL, 32'h0);
      $display("test one-shot f2 done");
      close_out();
   end
endmodule : pot_timer_tb
